// ==== rtl/mcell_array.sv ====
// Top: eight configurable macrocells with preload, security, signature
`timescale 1ns/1ns
module mcell_array #(
  parameter int NCELL = mcell_pkg::NCELL,
  parameter int NPT   = mcell_pkg::NPT
) (
  input  wire logic                   CLK,        // System clock 50 MHz
  input  wire logic                   RESETN,     // Sync reset, power-up
  input  wire mcell_pkg::cfg_t        CFG,        // Static configuration
  input  wire logic                   CFG_LOAD,   // Load config from store
  input  wire logic                   ERASE,      // Erase pulse: config and security bit
  input  wire logic                   SEC_PROG,   // Program security bit
  input  wire logic                   SIG_WR,     // Write signature
  input  wire logic [63:0]            SIG_IN,     // Signature data
  input  wire logic [NCELL*NPT-1:0]   PT,         // Product terms per cell
  input  wire logic                   PIN_CLK,    // Clock pin as level
  input  wire logic                   PIN_OE_N,   // Enable pin, active low
  input  wire logic [NCELL-1:0]       PIN_IN,     // I/O pin levels
  input  wire logic                   PRELOAD,    // Preload strobe
  output logic [NCELL-1:0]            PIN_OUT,    // I/O pin drive values
  output logic [NCELL-1:0]            PIN_OE,     // I/O pin enables
  output logic [NCELL-1:0]            FB,         // Feedback into array
  output mcell_pkg::cfg_t             CFG_RD,     // Config readback
  output logic                        CFG_RD_OK,  // Readback permitted
  output logic [63:0]                 SIG_RD,     // Signature readback
  output logic                        SECURE      // Security bit state
);
  typedef struct packed {
    mcell_pkg::cfg_t  cfg;
    mcell_pkg::nv_t   nv;
    logic [NCELL-1:0] q;
    logic             clk_d;
  } state_t;

  state_t           st_r;
  state_t           st_nxt;
  logic [NCELL-1:0] d;
  logic [NCELL-1:0] adj;
  logic [NCELL-1:0] fbsel;

  // Adjacent pin per cell; end cells use enable and clock pins
  always_comb begin
    for (int i = 0; i < NCELL; i++) begin
      adj[i]   = (i < NCELL - 1) ? PIN_IN[(i + 1) % NCELL] : 1'b0;
      fbsel[i] = st_r.cfg.family_emulation_global;
    end
    adj[mcell_pkg::FIRST]   = PIN_OE_N;
    adj[mcell_pkg::LAST]    = PIN_CLK;
    fbsel[mcell_pkg::FIRST] =
      ~st_r.cfg.registers_allowed_global;
    fbsel[mcell_pkg::LAST]  =
      ~st_r.cfg.registers_allowed_global;
  end

  // One macrocell per output; terms arrive already evaluated
  for (genvar g = 0; g < NCELL; g++) begin : g_cell
    mcell_cell #(.NPT(NPT)) u_cell (
      .pt       (PT[g*NPT +: NPT]),
      .rg_allow (st_r.cfg.registers_allowed_global),
      .fam      (st_r.cfg.family_emulation_global),
      .fb_sel_g (fbsel[g]),
      .mode     (st_r.cfg.cell_mode_select[g]),
      .pol      (st_r.cfg.cell_polarity_select[g]),
      .oe_n     (PIN_OE_N),
      .q        (st_r.q[g]),
      .pin_in   (PIN_IN[g]),
      .adj_in   (adj[g]),
      .no_fb    (mcell_pkg::NOFB_MASK[g]),
      .d        (d[g]),
      .pin_out  (PIN_OUT[g]),
      .pin_oe   (PIN_OE[g]),
      .fb       (FB[g])
    );
  end

  // Next state: config, nonvolatile bits and cell registers
  always_comb begin
    st_nxt       = st_r;
    st_nxt.clk_d = PIN_CLK;
    // Config changes on an explicit load, which may come mid-run; erase clears it
    if (CFG_LOAD) begin
      st_nxt.cfg = CFG;
    end
    if (SEC_PROG) begin
      st_nxt.nv.secure = 1'b1;
    end
    if (SIG_WR) begin
      st_nxt.nv.signature = SIG_IN;
    end
    // Erase wipes the security bit together with the array
    if (ERASE) begin
      st_nxt.nv.secure = 1'b0;
      st_nxt.cfg       = '0;
    end
    // Rising edge of the clock pin, sampled on CLK
    if (PIN_CLK && !st_r.clk_d) begin
      st_nxt.q = ~d;
    end
    // Preload overrides a clock edge in the same cycle
    if (PRELOAD) begin
      st_nxt.q = ~PIN_IN;
    end
  end

  // Reset clears registers, config, the security bit and the signature
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_r.q     <= mcell_pkg::REG_RST;
      st_r.clk_d <= 1'b0;
      st_r.cfg   <= '0;
      st_r.nv    <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Readback gated by security; signature is always open
  assign CFG_RD    = st_r.nv.secure ? '0 : st_r.cfg;
  assign CFG_RD_OK = ~st_r.nv.secure;
  assign SIG_RD    = st_r.nv.signature;
  assign SECURE    = st_r.nv.secure;
endmodule : mcell_array

// ==== rtl/mcell_pkg.sv ====
// Package: constants and carrier types for the macrocell array
// ****************************************************************
// ****************************************************************
package mcell_pkg;
  localparam int NCELL   = 8;
  localparam int NPT     = 8;
  localparam int SIG_W   = 64;
  localparam int CFG_W   = 2 + 2 * NCELL;
  localparam int FIRST   = 0;
  localparam int LAST    = NCELL - 1;
  localparam int ENPT    = NPT - 1;
  // Cells whose feedback is dropped in combinatorial output mode
  localparam logic [NCELL-1:0] NOFB_MASK = 8'h18;
  localparam logic [NCELL-1:0] REG_RST   = 8'h00;

  typedef enum logic [2:0] {
    CM_REGOUT, CM_COMBOUT, CM_COMBIO_NR, CM_COMBIO_R, CM_INPUT, CM_ILLEGAL
  } cell_mode_t;

  typedef struct packed {
    logic             registers_allowed_global;
    logic             family_emulation_global;
    logic [NCELL-1:0] cell_mode_select;
    logic [NCELL-1:0] cell_polarity_select;
  } cfg_t;

  typedef struct packed {
    logic             secure;
    logic [SIG_W-1:0] signature;
  } nv_t;
endpackage : mcell_pkg

// ==== rtl/mcell_cell.sv ====
// One output macrocell: term sum, polarity, enable and feedback select
`timescale 1ns/1ns
module mcell_cell #(
  parameter int NPT = 8
) (
  input  wire logic [NPT-1:0] pt,        // Product terms
  input  wire logic           rg_allow,  // Registers-allowed bit
  input  wire logic           fam,       // Family-emulation bit
  input  wire logic           fb_sel_g,  // Global bit for feedback mux
  input  wire logic           mode,      // Cell mode bit
  input  wire logic           pol,       // Polarity bit
  input  wire logic           oe_n,      // Enable pin, active low
  input  wire logic           q,         // Register state
  input  wire logic           pin_in,    // Own pin level
  input  wire logic           adj_in,    // Adjacent pin level
  input  wire logic           no_fb,     // Cell drops feedback in comb out
  output logic                d,         // Next register value
  output logic                pin_out,   // Pin drive value
  output logic                pin_oe,    // Pin driven
  output logic                fb         // Feedback into array
);
  logic [2:0] sel;
  logic       sum;
  mcell_pkg::cell_mode_t cm;

  // Mode decode from the three control bits
  always_comb begin
    sel = {rg_allow, fam, mode};
    unique case (sel)
      3'h2:    cm = mcell_pkg::CM_REGOUT;
      3'h4:    cm = mcell_pkg::CM_COMBOUT;
      3'h7:    cm = mcell_pkg::CM_COMBIO_NR;
      3'h3:    cm = mcell_pkg::CM_COMBIO_R;
      3'h5:    cm = mcell_pkg::CM_INPUT;
      default: cm = mcell_pkg::CM_ILLEGAL;
    endcase
  end

  // Eighth term joins the sum unless it serves as enable
  always_comb begin
    if (fam && mode) begin
      sum = |pt[NPT-2:0];
    end else begin
      sum = |pt;
    end
  end

  // XNOR polarity; register output pin shows inverted sense of Q bar
  assign d = sum ~^ pol;

  // Output and enable select; illegal codes keep the pin released
  always_comb begin
    pin_out = 1'b0;
    pin_oe  = 1'b0;
    unique case (cm)
      mcell_pkg::CM_REGOUT: begin
        pin_out = ~q;
        pin_oe  = ~oe_n;
      end
      mcell_pkg::CM_COMBOUT: begin
        pin_out = d;
        pin_oe  = 1'b1;
      end
      mcell_pkg::CM_COMBIO_NR, mcell_pkg::CM_COMBIO_R: begin
        pin_out = d;
        pin_oe  = pt[NPT-1];
      end
      default: begin
        pin_out = 1'b0;
        pin_oe  = 1'b0;
      end
    endcase
  end

  // Feedback select: end cells steer with inverted registers bit
  always_comb begin
    if (fb_sel_g) begin
      fb = mode ? pin_in : (cm == mcell_pkg::CM_REGOUT ? q : pin_in);
    end else begin
      fb = mode ? adj_in : (no_fb ? 1'b0 : pin_in);
    end
    if (cm == mcell_pkg::CM_REGOUT) begin
      fb = q;
    end
  end
endmodule : mcell_cell

// ==== tb/mcell_array_monitor.sv ====
// Checker: pin-level assertions for the macrocell array
`timescale 1ns/1ns
module mcell_mon #(parameter int NCELL = 8, parameter int NPT = 8) (
  input wire logic                 CLK,      // Clock
  input wire logic                 RESETN,   // Reset
  input wire logic [NCELL*NPT-1:0] PT,       // Terms
  input wire logic                 PIN_CLK,  // Clock pin
  input wire logic                 PIN_OE_N, // Enable pin
  input wire logic [NCELL-1:0]     PIN_IN,   // Pin levels
  input wire logic [NCELL-1:0]     PIN_OUT,  // Drive
  input wire logic [NCELL-1:0]     PIN_OE,   // Enables
  input wire logic [NCELL-1:0]     FB,       // Feedback
  input wire mcell_pkg::cfg_t      CFG_RD    // Config view
);
  logic [NCELL-1:0] s8, s7, ept;
  // Config via readback: zero while secure, so nothing fires then
  wire logic             rg  = CFG_RD.registers_allowed_global;
  wire logic             fam = CFG_RD.family_emulation_global;
  wire logic [NCELL-1:0] m   = CFG_RD.cell_mode_select;
  wire logic [NCELL-1:0] p   = CFG_RD.cell_polarity_select;
  // Sum of all terms, of seven terms, and the enable term
  always_comb for (int g = 0; g < NCELL; g++) begin
    s8[g]  = |PT[g*NPT +: NPT];
    s7[g]  = |PT[g*NPT +: NPT-1];
    ept[g] = PT[g*NPT+NPT-1];
  end
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  chk_reg_enable: assert property (
    !rg && fam |-> ((PIN_OE ^ ~{NCELL{PIN_OE_N}}) & ~m) == '0)
    else $error("reg enable");
  chk_nonreg_enable: assert property (
    rg && !fam |-> PIN_OE == ~m)
    else $error("nonreg enable");
  chk_io_enable: assert property (
    fam |-> ((PIN_OE ^ ept) & m) == '0)
    else $error("io enable");
  chk_comb_value: assert property (
    rg && !fam |-> ((PIN_OUT ^ s8 ^ ~p) & ~m) == '0)
    else $error("comb value");
  chk_io_value: assert property (
    fam |-> ((PIN_OUT ^ s7 ^ ~p) & m) == '0)
    else $error("io value");
  chk_io_feedback: assert property (
    fam |-> ((FB ^ PIN_IN) & m & ~{rg, {NCELL-2{1'b0}}, rg}) == '0)
    else $error("io feedback");
  chk_end_input: assert property (
    rg && !fam |-> (!m[0] || FB[0] == PIN_OE_N) &&
    (!m[NCELL-1] || FB[NCELL-1] == PIN_CLK))
    else $error("end cell input");
  chk_reg_capture: assert property (
    $rose(PIN_CLK) && !rg && fam |=>
    ((PIN_OUT ^ $past(s8) ^ ~p) & ~m) == '0)
    else $error("reg capture");
endmodule : mcell_mon
// Attach to every instance of the top
bind mcell_array mcell_mon #(.NCELL(NCELL), .NPT(NPT)) mon (.CLK, .RESETN,
  .PT, .PIN_CLK, .PIN_OE_N, .PIN_IN, .PIN_OUT, .PIN_OE, .FB, .CFG_RD);

// ==== tb/mcell_pins.sv ====
// Model of the board logic on the far side of the I/O pins
`timescale 1ns/1ns
module mcell_pins (
  input  wire logic [7:0] pin_out, // Device drive
  input  wire logic [7:0] pin_oe,  // Device enables
  input  wire logic [7:0] ext,     // Board drive
  output logic      [7:0] pin_in   // Wire level
);
  // Board drives only released pins, so the wire never fights
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : mcell_pins

// ==== tb/mcell_array_tb.sv ====
// Testbench: reset, configuration table, then clock, preload, security, erase, reset
`timescale 1ns/1ns
module mcell_array_tb;
  typedef struct packed {mcell_pkg::cfg_t c; logic [7:0] o, e, k;} row_t;
  logic CLK = 0, RESETN = 0, CFG_LOAD = 0, ERASE = 0, SEC_PROG = 0;
  logic SIG_WR = 0, PIN_CLK = 0, PIN_OE_N = 0, PRELOAD = 0, CFG_RD_OK, SECURE;
  logic [63:0] SIG_IN = 64'h0123_4567_89ab_cdef, SIG_RD;
  logic [63:0] PT = 64'h8001_0000_ff00_7f80;
  logic [7:0]  PIN_IN, PIN_OUT, PIN_OE, FB, ext = 8'h5a;
  mcell_pkg::cfg_t CFG = '0, CFG_RD;
  int          bad_count = 0, check_count = 0;
  row_t        rows [5] = '{
    {2'b10, 8'h00, 8'h0f, 8'h3b, 8'hff, 8'hff},
    {2'b11, 8'hff, 8'h33, 8'h86, 8'h89, 8'hff},
    {2'b01, 8'hff, 8'haa, 8'h1f, 8'h89, 8'hff},
    {2'b10, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00},
    {2'b10, 8'h0f, 8'hf0, 8'hc0, 8'hf0, 8'hf0}};
  // Free-running 50 MHz clock
  always #10 CLK = ~CLK;
  mcell_array uut (.CLK, .RESETN, .CFG, .CFG_LOAD, .ERASE, .SEC_PROG,
    .SIG_WR, .SIG_IN, .PT, .PIN_CLK, .PIN_OE_N, .PIN_IN, .PRELOAD, .PIN_OUT,
    .PIN_OE, .FB, .CFG_RD, .CFG_RD_OK, .SIG_RD, .SECURE);
  mcell_pins pins (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext, .pin_in(PIN_IN));
  // Strobe for one edge, then an idle edge so strobes never collide
  task automatic pulse(ref logic s);
    s = 1;
    @(posedge CLK) #2 s = 0;
    @(posedge CLK) #2;
  endtask : pulse
  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    check_count++;
    if (seen !== exp) bad_count++;
    if (seen !== exp) $display("BAD %0t: saw %h want %h", $time, seen, exp);
  endtask : chk
  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // Main sequence; fixed waits only, as every answer has a set latency
  initial begin
    repeat (10) @(posedge CLK) #2;
    RESETN = 1;
    foreach (rows[i]) begin
      CFG = rows[i].c;
      pulse(CFG_LOAD);
      chk(PIN_OUT & rows[i].k, rows[i].o);
      chk(PIN_OE, rows[i].e);
    end
    // Last row: input cells 1-3 take the next pin, cell 0 the enable pin, cell 4 drops feedback
    chk(FB, 8'hc4);
    CFG = {2'b01, 8'h00, 8'hff};
    pulse(CFG_LOAD);
    chk(PIN_OUT, 8'hff);
    pulse(PIN_CLK);
    chk(PIN_OUT, 8'hcb);
    chk(FB, 8'h34);
    PIN_OE_N = 1;
    pulse(PRELOAD);
    chk(PIN_OE, 8'h00);
    PIN_OE_N = 0;
    chk(PIN_OUT, 8'h5a);
    pulse(SIG_WR);
    chk(CFG_RD, CFG);
    chk(CFG_RD_OK, 1);
    pulse(SEC_PROG);
    chk(SECURE, 1);
    chk(CFG_RD, 0);
    chk(CFG_RD_OK, 0);
    chk(SIG_RD, SIG_IN);
    pulse(ERASE);
    chk(SECURE, 0);
    chk(CFG_RD_OK, 1);
    // Mid-run reset: preloaded state must go, so pins read high again
    RESETN = 0;
    @(posedge CLK) #2;
    RESETN = 1;
    pulse(CFG_LOAD);
    chk(PIN_OUT, 8'hff);
    summarize();
  end
endmodule : mcell_array_tb
